// File: srcq_pkg.sv
package srcq_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BADSRC_MS = 30;
  localparam int RETRY_MS = 2000;
  localparam int DCD_MS = 500;
  localparam int HV_MS = 100;
  localparam int OPT_STEP_MS = 10;
  localparam int INT_US = 1;
  localparam int BADSRC_CYC = BADSRC_MS * CLK_MHZ * 1000;
  localparam int RETRY_CYC = RETRY_MS * CLK_MHZ * 1000;
  localparam int DCD_CYC = DCD_MS * CLK_MHZ * 1000;
  localparam int HV_CYC = HV_MS * CLK_MHZ * 1000;
  localparam int OPT_STEP_CYC = OPT_STEP_MS * CLK_MHZ * 1000;
  localparam int INT_CYC = INT_US * CLK_MHZ;
  localparam int TMR_W = 29;
  typedef logic [TMR_W-1:0] tmr_t;
  typedef logic [7:0] intc_t;

  // ------------------------------------------------------------------
  // Limits: current in 50 mA steps, voltage in 100 mV steps
  // ------------------------------------------------------------------
  typedef logic [6:0] limit_pin_t;
  localparam limit_pin_t LIMIT_PIN_200MA = 7'h04;
  localparam limit_pin_t LIMIT_PIN_500MA = 7'h0A;
  localparam limit_pin_t LIMIT_PIN_1A = 7'h14;
  localparam limit_pin_t LIMIT_PIN_1P5A = 7'h1E;
  localparam limit_pin_t LIMIT_PIN_2A = 7'h28;
  localparam limit_pin_t LIMIT_PIN_2P1A = 7'h2A;
  localparam limit_pin_t LIMIT_PIN_2P4A = 7'h30;
  localparam limit_pin_t LIMIT_PIN_3P25A = 7'h41;
  localparam limit_pin_t LIMIT_PIN_STEP = 7'h01;
  localparam limit_pin_t LIMIT_PIN_RST = 7'h0A;
  typedef logic [7:0] vlim_t;
  localparam vlim_t VLIM_MIN = 8'h27;
  localparam vlim_t VLIM_RST = 8'h2B;
  typedef logic [4:0] vofs_t;
  localparam vofs_t VOFS_RST = 5'h06;

  // ------------------------------------------------------------------
  // Source codes and comparator classes
  // ------------------------------------------------------------------
  typedef logic [2:0] src_t;
  localparam src_t SRC_NONE = 3'h0;
  localparam src_t SRC_SDP = 3'h1;
  localparam src_t SRC_CDP = 3'h2;
  localparam src_t SRC_DCP = 3'h3;
  localparam src_t SRC_HV = 3'h4;
  localparam src_t SRC_UNK = 3'h5;
  localparam src_t SRC_NSTD = 3'h6;
  typedef logic [1:0] bc_t;
  localparam bc_t BC_SDP = 2'h1;
  localparam bc_t BC_CDP = 2'h2;
  localparam bc_t BC_DCP = 2'h3;
  localparam logic [1:0] WIN_1P2 = 2'h1;
  localparam logic [1:0] WIN_2P0 = 2'h2;
  localparam logic [1:0] WIN_2P7 = 2'h3;

  typedef struct packed {
    logic contact;
    bc_t bc_class;
    logic [1:0] dp_win;
    logic [1:0] dm_win;
  } dpdm_sense_t;

  typedef struct packed {
    logic dp_src;
    logic dp_sink;
    logic dm_src;
    logic dm_sink;
  } dpdm_drive_t;

  typedef struct packed {
    logic charge_enable;
    logic limit_pin_enable;
    logic force_optimizer;
    logic optimizer_enable;
    logic absolute_vlimit_select;
    logic force_port_detect;
    logic hv_charger_enable;
    logic vendor_hv_enable;
    logic auto_port_detect_enable;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = 9'h1A1;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  typedef logic [7:0] addr_t;
  localparam addr_t A_CTRL = 8'h00;
  localparam addr_t A_LIMIT_PIN = 8'h04;
  localparam addr_t A_VLIM = 8'h08;
  localparam addr_t A_VOFS = 8'h0C;
  localparam addr_t A_STAT = 8'h10;
  localparam addr_t A_OPT = 8'h14;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_REGUP = 4'h1,
    ST_QUAL = 4'h2,
    ST_RETRY = 4'h3,
    ST_DETECT = 4'h4,
    ST_HV = 4'h5,
    ST_VLIM = 4'h6,
    ST_CONV = 4'h7,
    ST_OPT = 4'h8,
    ST_RUN = 4'h9
  } state_t;

endpackage : srcq_pkg

// File: input_source_qualify_detect.sv
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
module input_source_qualify_detect #(
  parameter int T_BADSRC_CYC = srcq_pkg::BADSRC_CYC,
  parameter int T_RETRY_CYC = srcq_pkg::RETRY_CYC,
  parameter int T_DCD_CYC = srcq_pkg::DCD_CYC,
  parameter int T_HV_CYC = srcq_pkg::HV_CYC,
  parameter int T_OPT_STEP_CYC = srcq_pkg::OPT_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire srcq_pkg::addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vbus_present,
  input wire logic regulator_up,
  input wire logic vbus_below_ovp,
  input wire logic vbus_above_min,
  input wire srcq_pkg::dpdm_sense_t dpdm_sense,
  input wire logic vbus_raised,
  input wire srcq_pkg::vlim_t vbus_level,
  input wire logic sys_above_2v2,
  input wire logic vlimit_active,
  input wire srcq_pkg::limit_pin_t limit_pin,
  output logic regulator_en,
  output logic test_load_en,
  output srcq_pkg::dpdm_drive_t dpdm_drive,
  output logic converter_en,
  output logic battery_switch,
  output srcq_pkg::limit_pin_t eff_limit,
  output logic int_n
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  srcq_pkg::state_t state_r, state_nxt;
  srcq_pkg::tmr_t timer_r, timer_nxt;
  srcq_pkg::ctrl_t ctrl_r, ctrl_nxt;
  srcq_pkg::limit_pin_t limit_pin_r, limit_pin_nxt, opt_r, opt_nxt, eff_nxt, det_lim;
  srcq_pkg::vlim_t vlim_r, vlim_nxt;
  srcq_pkg::vofs_t vofs_r;
  srcq_pkg::src_t src_r, det_src;
  srcq_pkg::dpdm_drive_t drive_nxt;
  srcq_pkg::intc_t int_cnt_r, int_cnt_nxt;
  logic [4:0] int_pend_r, int_pend_nxt;
  logic input_good_r, power_good_r, std_port_r, conv_on_r;
  logic ev_good, det_done, ev_vlim, opt_start, opt_done, int_start;
  logic [31:0] rdata_nxt;
  logic addr_ok;

  function automatic srcq_pkg::limit_pin_t min_lim(srcq_pkg::limit_pin_t a,
                                              srcq_pkg::limit_pin_t b);
    return (a < b) ? a : b;
  endfunction : min_lim

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  wire wr_ctrl = wr_en && (paddr == srcq_pkg::A_CTRL);
  wire wr_limit_pin = wr_en && (paddr == srcq_pkg::A_LIMIT_PIN);
  // Voltage limit is only writable in absolute mode
  wire wr_vlim = wr_en && (paddr == srcq_pkg::A_VLIM)
                 && ctrl_r.absolute_vlimit_select;
  wire wr_vofs = wr_en && (paddr == srcq_pkg::A_VOFS);
  wire hv_any = ctrl_r.vendor_hv_enable | ctrl_r.hv_charger_enable;
  wire qual_ok = vbus_below_ovp & vbus_above_min;
  wire tmr_done = (timer_r == '0);
  wire opt_auto = ctrl_r.optimizer_enable
                  && (src_r == srcq_pkg::SRC_DCP || src_r == srcq_pkg::SRC_HV);
  wire [8:0] vlim_calc = {1'b0, vbus_level} - {4'h0, vofs_r};
  wire [1:0] dpw = dpdm_sense.dp_win;
  wire [1:0] dmw = dpdm_sense.dm_win;

  always_comb begin
    addr_ok = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      srcq_pkg::A_CTRL: rdata_nxt = {23'h0, ctrl_r};
      srcq_pkg::A_LIMIT_PIN: rdata_nxt = {25'h0, limit_pin_r};
      srcq_pkg::A_VLIM: rdata_nxt = {24'h0, vlim_r};
      srcq_pkg::A_VOFS: rdata_nxt = {27'h0, vofs_r};
      srcq_pkg::A_STAT: rdata_nxt = {21'h0, conv_on_r, state_r, std_port_r,
                                     src_r, power_good_r, input_good_r};
      srcq_pkg::A_OPT: rdata_nxt = {17'h0, eff_limit, 1'b0, opt_r};
      default: addr_ok = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Source classification
  // ------------------------------------------------------------------
  always_comb begin
    det_src = srcq_pkg::SRC_UNK;
    det_lim = srcq_pkg::LIMIT_PIN_500MA;
    if (dpdm_sense.contact) begin
      case (dpdm_sense.bc_class)
        srcq_pkg::BC_SDP: begin
          det_src = srcq_pkg::SRC_SDP;
          det_lim = srcq_pkg::LIMIT_PIN_500MA;
        end
        srcq_pkg::BC_CDP: begin
          det_src = srcq_pkg::SRC_CDP;
          det_lim = srcq_pkg::LIMIT_PIN_1P5A;
        end
        srcq_pkg::BC_DCP: begin
          det_src = srcq_pkg::SRC_DCP;
          det_lim = srcq_pkg::LIMIT_PIN_3P25A;
        end
        default: ;
      endcase
    end else begin
      det_src = srcq_pkg::SRC_NSTD;
      if (dpw == srcq_pkg::WIN_2P7 && dmw == srcq_pkg::WIN_2P0)
        det_lim = srcq_pkg::LIMIT_PIN_2P1A;
      else if (dpw == srcq_pkg::WIN_1P2 && dmw == srcq_pkg::WIN_1P2)
        det_lim = srcq_pkg::LIMIT_PIN_2A;
      else if (dpw == srcq_pkg::WIN_2P0 && dmw == srcq_pkg::WIN_2P7)
        det_lim = srcq_pkg::LIMIT_PIN_1A;
      else if (dpw == srcq_pkg::WIN_2P7 && dmw == srcq_pkg::WIN_2P7)
        det_lim = srcq_pkg::LIMIT_PIN_2P4A;
      else begin
        det_src = srcq_pkg::SRC_UNK;
        det_lim = srcq_pkg::LIMIT_PIN_500MA;
      end
    end
  end

  // ------------------------------------------------------------------
  // Attach sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    timer_nxt = tmr_done ? timer_r : timer_r - 1'b1;
    ev_good = 1'b0;
    det_done = 1'b0;
    ev_vlim = 1'b0;
    opt_start = 1'b0;
    opt_done = 1'b0;
    opt_nxt = opt_r;
    case (state_r)
      srcq_pkg::ST_IDLE: if (vbus_present) state_nxt = srcq_pkg::ST_REGUP;
      srcq_pkg::ST_REGUP: if (regulator_up) begin
        state_nxt = srcq_pkg::ST_QUAL;
        timer_nxt = srcq_pkg::tmr_t'(T_BADSRC_CYC);
      end
      srcq_pkg::ST_QUAL: if (tmr_done) begin
        if (qual_ok) begin
          ev_good = 1'b1;
          timer_nxt = srcq_pkg::tmr_t'(T_DCD_CYC);
          state_nxt = ctrl_r.auto_port_detect_enable ? srcq_pkg::ST_DETECT
                      : srcq_pkg::ST_VLIM;
        end else begin
          state_nxt = srcq_pkg::ST_RETRY;
          timer_nxt = srcq_pkg::tmr_t'(T_RETRY_CYC);
        end
      end
      srcq_pkg::ST_RETRY: if (tmr_done) begin
        state_nxt = srcq_pkg::ST_QUAL;
        timer_nxt = srcq_pkg::tmr_t'(T_BADSRC_CYC);
      end
      srcq_pkg::ST_DETECT: if (dpdm_sense.contact || tmr_done) begin
        if (det_src == srcq_pkg::SRC_DCP && hv_any) begin
          state_nxt = srcq_pkg::ST_HV;
          timer_nxt = srcq_pkg::tmr_t'(T_HV_CYC);
        end else begin
          det_done = 1'b1;
          state_nxt = srcq_pkg::ST_VLIM;
        end
      end
      srcq_pkg::ST_HV: if (tmr_done) begin
        det_done = 1'b1;
        state_nxt = srcq_pkg::ST_VLIM;
      end
      srcq_pkg::ST_VLIM: begin
        ev_vlim = 1'b1;
        state_nxt = srcq_pkg::ST_CONV;
      end
      srcq_pkg::ST_CONV: begin
        state_nxt = srcq_pkg::ST_RUN;
        if (opt_auto || ctrl_r.force_optimizer) begin
          opt_start = 1'b1;
          state_nxt = srcq_pkg::ST_OPT;
        end
      end
      srcq_pkg::ST_OPT: if (tmr_done) begin
        // Step down while the voltage limit still bites
        if (vlimit_active && opt_r > srcq_pkg::LIMIT_PIN_200MA) begin
          opt_nxt = opt_r - srcq_pkg::LIMIT_PIN_STEP;
          timer_nxt = srcq_pkg::tmr_t'(T_OPT_STEP_CYC);
        end else begin
          opt_done = 1'b1;
          state_nxt = srcq_pkg::ST_RUN;
        end
      end
      srcq_pkg::ST_RUN: begin
        if (ctrl_r.force_port_detect) begin
          state_nxt = srcq_pkg::ST_DETECT;
          timer_nxt = srcq_pkg::tmr_t'(T_DCD_CYC);
        end else if (ctrl_r.force_optimizer) begin
          opt_start = 1'b1;
          state_nxt = srcq_pkg::ST_OPT;
        end
      end
      default: state_nxt = srcq_pkg::ST_IDLE;
    endcase
    if (opt_start) begin
      opt_nxt = limit_pin_r;
      timer_nxt = srcq_pkg::tmr_t'(T_OPT_STEP_CYC);
    end
    if (!vbus_present) state_nxt = srcq_pkg::ST_IDLE;
  end

  // ------------------------------------------------------------------
  // Register and limit next values
  // ------------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (det_done) ctrl_nxt.force_port_detect = 1'b0;
    if (opt_done) ctrl_nxt.force_optimizer = 1'b0;
    // A host write in the same cycle wins over the self clear
    if (wr_ctrl) ctrl_nxt = srcq_pkg::ctrl_t'(pwdata[8:0]);
  end

  wire hv_ok = (state_r == srcq_pkg::ST_HV) && vbus_raised;
  wire srcq_pkg::src_t fin_src = hv_ok ? srcq_pkg::SRC_HV : det_src;
  wire srcq_pkg::limit_pin_t fin_lim = hv_ok ? srcq_pkg::LIMIT_PIN_1P5A : det_lim;
  assign limit_pin_nxt = wr_limit_pin ? pwdata[6:0] : det_done ? fin_lim : limit_pin_r;
  assign vlim_nxt = wr_vlim ? pwdata[7:0]
                  : (ev_vlim && !ctrl_r.absolute_vlimit_select)
                  ? ((vlim_calc[8] || vlim_calc[7:0] < srcq_pkg::VLIM_MIN)
                    ? srcq_pkg::VLIM_MIN : vlim_calc[7:0])
                  : vlim_r;

  wire srcq_pkg::limit_pin_t base_lim = ctrl_r.optimizer_enable ? opt_r : limit_pin_r;
  wire srcq_pkg::limit_pin_t soft_lim = min_lim(srcq_pkg::LIMIT_PIN_200MA, limit_pin_r);
  wire srcq_pkg::limit_pin_t run_lim = sys_above_2v2 ? base_lim : soft_lim;
  assign eff_nxt = ctrl_r.limit_pin_enable
                 ? min_lim(run_lim, limit_pin) : run_lim;

  // High voltage request: vendor bit asks 12 V, else 9 V
  always_comb begin
    drive_nxt = '0;
    if (state_nxt == srcq_pkg::ST_HV) begin
      if (ctrl_r.vendor_hv_enable) begin
        drive_nxt.dp_sink = 1'b1;
        drive_nxt.dm_src = 1'b1;
      end else begin
        drive_nxt.dp_src = 1'b1;
        drive_nxt.dm_sink = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupt pulses: events queue so none merge or drop
  // ------------------------------------------------------------------
  wire [1:0] ev_cnt = {1'b0, ev_good} + {1'b0, det_done} + {1'b0, ev_vlim};
  assign int_start = (int_cnt_r == '0) && int_n && (int_pend_r != '0);
  always_comb begin
    int_pend_nxt = int_pend_r + {3'h0, ev_cnt} - {4'h0, int_start};
    int_cnt_nxt = int_cnt_r;
    if (int_start) int_cnt_nxt = srcq_pkg::intc_t'(srcq_pkg::INT_CYC);
    else if (int_cnt_r != '0) int_cnt_nxt = int_cnt_r - 1'b1;
  end

  // ------------------------------------------------------------------
  // Flip-flops
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= srcq_pkg::ST_IDLE;
      timer_r <= '0;
      ctrl_r <= srcq_pkg::CTRL_RST;
      limit_pin_r <= srcq_pkg::LIMIT_PIN_RST;
      vlim_r <= srcq_pkg::VLIM_RST;
      vofs_r <= srcq_pkg::VOFS_RST;
      opt_r <= srcq_pkg::LIMIT_PIN_RST;
      src_r <= srcq_pkg::SRC_NONE;
      std_port_r <= 1'b0;
      input_good_r <= 1'b0;
      power_good_r <= 1'b0;
      conv_on_r <= 1'b0;
      int_pend_r <= '0;
      int_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      ctrl_r <= ctrl_nxt;
      limit_pin_r <= limit_pin_nxt;
      vlim_r <= vlim_nxt;
      if (wr_vofs) vofs_r <= pwdata[4:0];
      opt_r <= opt_nxt;
      if (det_done) begin
        src_r <= fin_src;
        std_port_r <= (fin_src == srcq_pkg::SRC_SDP);
      end
      input_good_r <= (input_good_r | ev_good) & vbus_present;
      power_good_r <= (power_good_r | det_done
                      | (ev_good & ~ctrl_r.auto_port_detect_enable))
                      & vbus_present;
      conv_on_r <= (conv_on_r | (state_r == srcq_pkg::ST_CONV))
                   & vbus_present;
      int_pend_r <= int_pend_nxt;
      int_cnt_r <= int_cnt_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      regulator_en <= 1'b0;
      test_load_en <= 1'b0;
      dpdm_drive <= '0;
      converter_en <= 1'b0;
      battery_switch <= 1'b0;
      eff_limit <= srcq_pkg::LIMIT_PIN_RST;
      int_n <= 1'b1;
    end else begin
      prdata <= (setup_ph && !pwrite) ? rdata_nxt : 32'h0000_0000;
      pready <= setup_ph;
      pslverr <= setup_ph && !addr_ok;
      regulator_en <= (state_nxt != srcq_pkg::ST_IDLE);
      test_load_en <= (state_nxt == srcq_pkg::ST_QUAL);
      dpdm_drive <= drive_nxt;
      converter_en <= conv_on_r & vbus_present;
      battery_switch <= ~(conv_on_r & ~ctrl_r.charge_enable);
      eff_limit <= eff_nxt;
      int_n <= (int_cnt_nxt == '0);
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  localparam int INT_WAIT = 800;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hv_enter;
    state_r != srcq_pkg::ST_HV ##1 state_r == srcq_pkg::ST_HV;
  endsequence
  sequence s_pulse_start;
    int_n ##1 !int_n;
  endsequence

  a_qual_load: assert property (
    state_r == srcq_pkg::ST_QUAL |-> test_load_en)
    else $error("test load off during qualification");
  a_good_irq: assert property ($rose(input_good_r) |-> ##[0:INT_WAIT] !int_n)
    else $error("no interrupt after input good");
  a_retry_load: assert property (
    $rose(state_r == srcq_pkg::ST_RETRY)
    |-> timer_r == srcq_pkg::tmr_t'(T_RETRY_CYC))
    else $error("retry wait not loaded with 2 s");
  a_skip_detect: assert property (
    (state_r == srcq_pkg::ST_QUAL && tmr_done && qual_ok
     && !ctrl_r.auto_port_detect_enable && vbus_present)
    |=> state_r == srcq_pkg::ST_VLIM && $stable(src_r))
    else $error("detection not skipped");
  a_detect_done: assert property (
    (det_done && !wr_limit_pin && vbus_present)
    |=> power_good_r && limit_pin_r == $past(fin_lim))
    else $error("detection result not written");
  a_pin_clamp: assert property (
    $past(ctrl_r.limit_pin_enable) |-> eff_limit <= $past(limit_pin))
    else $error("limit pin not clamping");
  a_soft_start: assert property (
    !sys_above_2v2 |=> eff_limit <= srcq_pkg::LIMIT_PIN_200MA)
    else $error("soft start limit exceeded");
  a_hv_drive: assert property (
    s_hv_enter |-> (ctrl_r.vendor_hv_enable
      ? (dpdm_drive.dp_sink && dpdm_drive.dm_src)
      : (dpdm_drive.dp_src && dpdm_drive.dm_sink)))
    else $error("wrong handshake drive");
  a_force_clear: assert property (
    (det_done && !wr_ctrl) |=> !ctrl_r.force_port_detect)
    else $error("force detect not cleared");
  a_vlim_ro: assert property (
    (!ctrl_r.absolute_vlimit_select && !ev_vlim) |=> $stable(vlim_r))
    else $error("voltage limit changed in relative mode");
  a_int_width: assert property (s_pulse_start |-> (!int_n) [*8])
    else $error("interrupt pulse too short");

endmodule : input_source_qualify_detect

// File: port_model.sv
`timescale 1ns/100ps
module port_model (
  input wire logic pclk,
  input wire logic [3:0] kind,
  input wire srcq_pkg::dpdm_drive_t dpdm_drive,
  output srcq_pkg::dpdm_sense_t dpdm_sense,
  output logic vbus_raised
);
  logic hv_req;

  assign hv_req = (dpdm_drive.dp_sink && dpdm_drive.dm_src) ||
    (dpdm_drive.dp_src && dpdm_drive.dm_sink);

  // --------------------------------------------------------------
  // Line levels per attached source {contact, class, dp, dm}
  // --------------------------------------------------------------
  always_comb begin
    case (kind)
      4'h0: dpdm_sense = 7'h50;
      4'h1: dpdm_sense = 7'h60;
      4'h2, 4'h3: dpdm_sense = 7'h70;
      4'h4: dpdm_sense = 7'h0E;
      4'h5: dpdm_sense = 7'h05;
      4'h6: dpdm_sense = 7'h0B;
      4'h7: dpdm_sense = 7'h0F;
      default: dpdm_sense = 7'h00;
    endcase
  end

  // Only the capable adapter raises, and it keeps the raised output
  always_ff @(posedge pclk) begin
    vbus_raised <= (kind == 4'h3) && (vbus_raised || hv_req);
  end
endmodule : port_model

// File: tb.sv
`timescale 1ns/100ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  srcq_pkg::addr_t paddr;
  logic [31:0] pwdata, prdata, rd;
  logic vbus_present, regulator_up, vbus_above_min, sys_above_2v2;
  logic vbus_raised, converter_en, battery_switch, int_n;
  logic regulator_en, test_load_en, vbus_below_ovp, vlimit_active;
  srcq_pkg::vlim_t vbus_level;
  srcq_pkg::dpdm_sense_t dpdm_sense;
  srcq_pkg::dpdm_drive_t dpdm_drive;
  srcq_pkg::limit_pin_t limit_pin, eff_limit;
  logic [3:0] kind;
  int failures, checked, ints, lowc;
  logic [3:0] kinds [9] = '{1, 2, 3, 4, 5, 6, 7, 8, 3};
  logic [2:0] codes [9] = '{2, 3, 4, 6, 6, 6, 6, 5, 4};
  logic [6:0] lims [9] = '{7'h1E, 7'h41, 7'h1E, 7'h2A, 7'h28, 7'h14,
    7'h30, 7'h0A, 7'h1E};

  // --------------------------------------------------------------
  // Design and far side
  // --------------------------------------------------------------
  input_source_qualify_detect #(.T_BADSRC_CYC(20), .T_RETRY_CYC(50),
    .T_DCD_CYC(40), .T_HV_CYC(30), .T_OPT_STEP_CYC(10)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vbus_present(vbus_present),
    .regulator_up(regulator_up), .vbus_below_ovp(vbus_below_ovp),
    .vbus_above_min(vbus_above_min), .dpdm_sense(dpdm_sense),
    .vbus_raised(vbus_raised), .vbus_level(vbus_level),
    .sys_above_2v2(sys_above_2v2), .vlimit_active(vlimit_active),
    .limit_pin(limit_pin), .regulator_en(regulator_en),
    .test_load_en(test_load_en),
    .dpdm_drive(dpdm_drive), .converter_en(converter_en),
    .battery_switch(battery_switch), .eff_limit(eff_limit),
    .int_n(int_n));
  port_model pm (.pclk(pclk), .kind(kind), .dpdm_drive(dpdm_drive),
    .dpdm_sense(dpdm_sense), .vbus_raised(vbus_raised));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(negedge int_n) if (presetn) ints++;
  always @(posedge pclk) if (presetn && int_n === 1'b0) lowc++;

  // --------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input srcq_pkg::addr_t a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rc(input string nm, input srcq_pkg::addr_t a,
      input logic [31:0] m, exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, exp);
  endtask : rc
  // Polls rather than counting cycles: detection length depends on source
  task automatic wt(input srcq_pkg::addr_t a, input logic [31:0] m, v);
    do begin
      apb(1'b0, a, 32'h0);
    end while ((rd & m) !== v);
  endtask : wt
  task automatic complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    #(4 * 40000);
    failures++;
    complete_run();
  end

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {vbus_present, regulator_up, vbus_above_min, kind} = '0;
    sys_above_2v2 = 1'b1;
    vbus_below_ovp = 1'b1;
    vlimit_active = 1'b0;
    vbus_level = 8'h32;
    limit_pin = 7'h7F;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl", srcq_pkg::A_CTRL, 32'hFFFFFFFF, 32'h1A1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    vbus_present <= 1'b1;
    regulator_up <= 1'b1;
    repeat (150) @(posedge pclk);
    rc("qual fail", srcq_pkg::A_STAT, 32'h3, 32'h0);
    vbus_above_min <= 1'b1;
    wt(srcq_pkg::A_STAT, 32'h400, 32'h400);
    rc("attach", srcq_pkg::A_STAT, 32'h3F, 32'h27);
    rc("sdp limit", srcq_pkg::A_LIMIT_PIN, 32'h7F, 32'h0A);
    repeat (800) @(posedge pclk);
    chk("ints", 32'(ints), 32'h3);
    chk("bat on", {converter_en, battery_switch}, 32'h3);
    rc("vlim rel", srcq_pkg::A_VLIM, 32'hFF, 32'h2C);
    apb(1'b1, srcq_pkg::A_VLIM, 32'h50);
    rc("vlim ro", srcq_pkg::A_VLIM, 32'hFF, 32'h2C);
    apb(1'b1, srcq_pkg::A_CTRL, 32'h091);
    apb(1'b1, srcq_pkg::A_VLIM, 32'h50);
    rc("vlim abs", srcq_pkg::A_VLIM, 32'hFF, 32'h50);
    chk("bat off", {converter_en, battery_switch}, 32'h2);
    for (int i = 0; i < 9; i++) begin
      kind <= kinds[i];
      apb(1'b1, srcq_pkg::A_CTRL, (i == 8) ? 32'h18D : 32'h18B);
      wt(srcq_pkg::A_CTRL, 32'h8, 32'h0);
      rc("code", srcq_pkg::A_STAT, 32'h1C, {codes[i], 2'h0});
      rc("limit", srcq_pkg::A_LIMIT_PIN, 32'h7F, {25'h0, lims[i]});
      chk("eff", {25'h0, eff_limit}, {25'h0, lims[i]});
    end
    sys_above_2v2 <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("soft start", {25'h0, eff_limit}, 32'h04);
    sys_above_2v2 <= 1'b1;
    limit_pin <= 7'h10;
    repeat (4) @(posedge pclk);
    chk("pin clamp", {25'h0, eff_limit}, 32'h10);
    apb(1'b1, srcq_pkg::A_CTRL, 32'h101);
    repeat (4) @(posedge pclk);
    chk("pin off", {25'h0, eff_limit}, 32'h1E);
    apb(1'b1, srcq_pkg::A_LIMIT_PIN, 32'h08);
    repeat (4) @(posedge pclk);
    chk("host limit_pin", {25'h0, eff_limit}, 32'h08);
    vlimit_active <= 1'b1;
    apb(1'b1, srcq_pkg::A_CTRL, 32'h1E1);
    wt(srcq_pkg::A_CTRL, 32'h40, 32'h0);
    rc("opt", srcq_pkg::A_OPT, 32'h7F7F, 32'h0404);
    repeat (6000) @(posedge pclk);
    vbus_present <= 1'b0;
    apb(1'b1, srcq_pkg::A_CTRL, 32'h100);
    rc("detach", srcq_pkg::A_STAT, 32'h403, 32'h0);
    chk("off", {regulator_en, test_load_en, converter_en}, 32'h0);
    vbus_below_ovp <= 1'b0;
    vbus_level <= 8'h28;
    vbus_present <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("load on", {regulator_en, test_load_en}, 32'h3);
    repeat (40) @(posedge pclk);
    chk("load off", {regulator_en, test_load_en}, 32'h2);
    rc("ovp", srcq_pkg::A_STAT, 32'h1, 32'h0);
    vbus_below_ovp <= 1'b1;
    wt(srcq_pkg::A_STAT, 32'h400, 32'h400);
    rc("skip", srcq_pkg::A_STAT, 32'h3F, 32'h13);
    rc("skip lim", srcq_pkg::A_LIMIT_PIN, 32'h7F, 32'h08);
    rc("vlim floor", srcq_pkg::A_VLIM, 32'hFF, 32'h27);
    repeat (600) @(posedge pclk);
    chk("ints all", 32'(ints), 32'h17);
    chk("int width", 32'(lowc), 32'(250 * ints));
    complete_run();
  end
endmodule : tb
